// ---- adfw_params.svh ----
// Register offsets, field positions, widths and reset values of the converter flag and window watch block.
`ifndef ADFW_PARAMS_SVH
`define ADFW_PARAMS_SVH

`define ADFW_AW           8
`define ADFW_DW           32
`define ADFW_SW           12
`define ADFW_CW           4
`define ADFW_NFLAG        4

`define ADFW_OFF_FLAGS    8'h00
`define ADFW_OFF_WATCH    8'h04
`define ADFW_OFF_CTRL3    8'h0c
`define ADFW_OFF_LOG      8'h40
`define ADFW_OFF_MASK     8'h44

`define ADFW_FLG_WINDOW   0
`define ADFW_FLG_GROUP    1
`define ADFW_FLG_BEGAN    2
`define ADFW_FLG_ANY      3

`define ADFW_WC_REGULAR   7
`define ADFW_WC_SINGLE    6
`define ADFW_WC_WIE       5
`define ADFW_WC_GDIE      4
`define ADFW_WC_SEL_HI    3
`define ADFW_WC_SEL_LO    0
`define ADFW_WC_WIDTH     8
`define ADFW_C3_ACIE      4

`define ADFW_CHAN_MAX     4'h9
`define ADFW_RST_FLAGS    4'h0
`define ADFW_RST_WATCH    8'h00
`define ADFW_RST_MASK     4'h0
`define ADFW_ZERO         32'h0000_0000

`endif

// ---- adfw_pkg.sv ----
// Types shared by the converter flag and window watch block.
`include "adfw_params.svh"

package adfw_pkg;

  typedef logic [`ADFW_SW-1:0]    adfw_sample_t;
  typedef logic [`ADFW_CW-1:0]    adfw_chan_t;
  typedef logic [`ADFW_NFLAG-1:0] adfw_flags_t;

  typedef enum logic [2:0]
  {
    ADFW_SEL_FLAGS = 3'b000,
    ADFW_SEL_WATCH = 3'b001,
    ADFW_SEL_CTRL3 = 3'b010,
    ADFW_SEL_LOG   = 3'b011,
    ADFW_SEL_MASK  = 3'b100,
    ADFW_SEL_NONE  = 3'b111
  } adfw_reg_sel_t;

endpackage : adfw_pkg

// ---- adfw_top.sv ----
// Converter status flags, window watch control and interrupt logic behind an APB slave.
`include "adfw_params.svh"

// How it works
// - Every finished regular channel conversion sets the any-channel-done flag, bit 3.
// - Every regular channel conversion start sets the conversion-began flag, bit 2.
// - Completion of the whole channel group sets the group-done flag, bit 1.
// - A result above the high or below the low limit sets window flag, bit 0.
// - Window checking runs only while the regular watch enable, bit 7, is one.
// - Single channel watch bit 6 limits checking to the selected channel; else all.
// - Window interrupt requested only with watch interrupt enable bit 5 and flag set, or via the event log with mask bit 0 set.
// - In scan mode a window hit aborts the scan only while bit 5 is set.
// - Group-done interrupt requested only with group-done interrupt enable bit 4 set, or via the event log with mask bit 1 set.
// - Four-bit select field picks channel 0 to 9; other codes are reserved.
// - The conversion-began flag has no interrupt enable; its event interrupts only through the event log with mask bit 2 set.
// - Any-channel-done interrupt requested only with its enable in control register 3, or via the event log with mask bit 3 set.
// - In scan mode group-done sets only after the last sequence channel converts.
module adfw_top
(
  input  wire logic                   sys_clk,
  input  wire logic                   nrst,
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire logic [`ADFW_AW-1:0]    paddr,
  input  wire logic [`ADFW_DW-1:0]    pwdata,
  output logic      [`ADFW_DW-1:0]    prdata,
  output logic                        pready,
  output logic                        pslverr,
  input  wire logic                   conv_start,
  input  wire logic                   conv_done,
  input  wire adfw_pkg::adfw_chan_t   conv_channel,
  input  wire adfw_pkg::adfw_sample_t conv_result,
  input  wire logic                   conv_last,
  input  wire logic                   sequence_scan_enable,
  input  wire adfw_pkg::adfw_sample_t window_high_limit,
  input  wire adfw_pkg::adfw_sample_t window_low_limit,
  output logic                        scan_abort,
  output logic                        irq
);

  ////////////////////////////////////////////////////////////////////////////
  // Register state and decode.

  adfw_pkg::adfw_flags_t         event_flags;
  logic [`ADFW_WC_WIDTH-1:0]     watch_control;
  logic                          any_channel_interrupt_enable;
  adfw_pkg::adfw_flags_t         event_log;
  adfw_pkg::adfw_flags_t         event_mask;
  adfw_pkg::adfw_flags_t         events;
  adfw_pkg::adfw_flags_t         next_event_flags;
  adfw_pkg::adfw_flags_t         next_event_log;
  adfw_pkg::adfw_reg_sel_t       sel;
  logic [`ADFW_DW-1:0]           next_prdata;
  logic                          wr_access;
  logic                          rd_access;
  logic                          rd_setup;
  logic                          regular_watch_enable;
  logic                          single_channel_watch;
  logic                          watch_interrupt_enable;
  logic                          group_done_interrupt_enable;
  adfw_pkg::adfw_chan_t          watched_channel_select;
  logic                          outside;
  logic                          channel_in_scope;
  logic                          watch_hit;
  logic                          group_end;

  assign regular_watch_enable        = watch_control[`ADFW_WC_REGULAR];
  assign single_channel_watch        = watch_control[`ADFW_WC_SINGLE];
  assign watch_interrupt_enable      = watch_control[`ADFW_WC_WIE];
  assign group_done_interrupt_enable = watch_control[`ADFW_WC_GDIE];
  assign watched_channel_select      = watch_control[`ADFW_WC_SEL_HI:`ADFW_WC_SEL_LO];

  always_comb
  begin
    case (paddr)
      `ADFW_OFF_FLAGS: sel = adfw_pkg::ADFW_SEL_FLAGS;
      `ADFW_OFF_WATCH: sel = adfw_pkg::ADFW_SEL_WATCH;
      `ADFW_OFF_CTRL3: sel = adfw_pkg::ADFW_SEL_CTRL3;
      `ADFW_OFF_LOG:   sel = adfw_pkg::ADFW_SEL_LOG;
      `ADFW_OFF_MASK:  sel = adfw_pkg::ADFW_SEL_MASK;
      default:         sel = adfw_pkg::ADFW_SEL_NONE;
    endcase
  end

  // Zero wait states; unmapped addresses answer with an error.
  assign pready    = 1'b1;
  assign pslverr   = psel && penable && (sel == adfw_pkg::ADFW_SEL_NONE);
  assign wr_access = psel && penable && pwrite;
  assign rd_access = psel && penable && !pwrite;
  assign rd_setup  = psel && !penable && !pwrite;

  ////////////////////////////////////////////////////////////////////////////
  // Window watch.

  adfw_window_cmp u_cmp
  (
    .sample     (conv_result),
    .high_limit (window_high_limit),
    .low_limit  (window_low_limit),
    .outside    (outside)
  );

  // A reserved select code above nine matches no channel.
  assign channel_in_scope = !single_channel_watch ||
                            ((conv_channel == watched_channel_select) &&
                             (watched_channel_select <= `ADFW_CHAN_MAX));
  assign watch_hit = conv_done && regular_watch_enable && channel_in_scope && outside;

  // Outside scan mode every conversion ends the group.
  assign group_end = conv_done && (!sequence_scan_enable || conv_last);

  always_comb
  begin
    events                  = '0;
    events[`ADFW_FLG_ANY]   = conv_done;
    events[`ADFW_FLG_BEGAN] = conv_start;
    events[`ADFW_FLG_GROUP] = group_end;
    events[`ADFW_FLG_WINDOW] = watch_hit;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Flag and log bits: a new event always wins over a clear in the same cycle.

  genvar gi;
  generate
    for (gi = 0; gi < `ADFW_NFLAG; gi = gi + 1)
    begin : g_bit
      always_comb
      begin
        if (wr_access && (sel == adfw_pkg::ADFW_SEL_FLAGS) && !pwdata[gi])
          next_event_flags[gi] = events[gi];
        else
          next_event_flags[gi] = event_flags[gi] | events[gi];
        if (rd_access && (sel == adfw_pkg::ADFW_SEL_LOG))
          next_event_log[gi] = events[gi];
        else
          next_event_log[gi] = event_log[gi] | events[gi];
      end
    end
  endgenerate

  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
      event_flags <= `ADFW_RST_FLAGS;
    else
      event_flags <= next_event_flags;
  end

  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
      event_log <= `ADFW_RST_FLAGS;
    else
      event_log <= next_event_log;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control registers; reserved write bits are dropped.

  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
      watch_control <= `ADFW_RST_WATCH;
    else if (wr_access && (sel == adfw_pkg::ADFW_SEL_WATCH))
      watch_control <= pwdata[`ADFW_WC_WIDTH-1:0];
  end

  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
      any_channel_interrupt_enable <= 1'b0;
    else if (wr_access && (sel == adfw_pkg::ADFW_SEL_CTRL3))
      any_channel_interrupt_enable <= pwdata[`ADFW_C3_ACIE];
  end

  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
      event_mask <= `ADFW_RST_MASK;
    else if (wr_access && (sel == adfw_pkg::ADFW_SEL_MASK))
      event_mask <= pwdata[`ADFW_NFLAG-1:0];
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read data, captured in the setup phase.

  always_comb
  begin
    next_prdata = `ADFW_ZERO;
    case (sel)
      adfw_pkg::ADFW_SEL_FLAGS: next_prdata[`ADFW_NFLAG-1:0] = event_flags;
      adfw_pkg::ADFW_SEL_WATCH: next_prdata[`ADFW_WC_WIDTH-1:0] = watch_control;
      adfw_pkg::ADFW_SEL_CTRL3: next_prdata[`ADFW_C3_ACIE] = any_channel_interrupt_enable;
      adfw_pkg::ADFW_SEL_LOG:   next_prdata[`ADFW_NFLAG-1:0] = event_log;
      adfw_pkg::ADFW_SEL_MASK:  next_prdata[`ADFW_NFLAG-1:0] = event_mask;
      default:                  next_prdata = `ADFW_ZERO;
    endcase
  end

  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
      prdata <= `ADFW_ZERO;
    else if (rd_setup)
      prdata <= next_prdata;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Scan abort and interrupt output.

  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
      scan_abort <= 1'b0;
    else
      scan_abort <= watch_hit && sequence_scan_enable && watch_interrupt_enable;
  end

  // The began flag has no enable; its event reaches the output only through the log with mask bit 2 set.
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
      irq <= 1'b0;
    else
      irq <= (next_event_flags[`ADFW_FLG_WINDOW] && watch_interrupt_enable) ||
             (next_event_flags[`ADFW_FLG_GROUP] && group_done_interrupt_enable) ||
             (next_event_flags[`ADFW_FLG_ANY] && any_channel_interrupt_enable) ||
             (|(next_event_log & event_mask));
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks.

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!nrst);

  property p_any_done;
    conv_done |=> event_flags[`ADFW_FLG_ANY];
  endproperty
  a_any_done: assert property (p_any_done) else $error("Any-done flag not set.");

  property p_began;
    conv_start |=> event_flags[`ADFW_FLG_BEGAN];
  endproperty
  a_began: assert property (p_began) else $error("Began flag not set.");

  property p_group_hold;
    event_flags[`ADFW_FLG_GROUP] && !(wr_access && (sel == adfw_pkg::ADFW_SEL_FLAGS))
      |=> event_flags[`ADFW_FLG_GROUP];
  endproperty
  a_group_hold: assert property (p_group_hold) else $error("Group flag lost without a clear.");

  property p_window_set;
    conv_done && regular_watch_enable && !single_channel_watch &&
      (conv_result > window_high_limit) |=> event_flags[`ADFW_FLG_WINDOW];
  endproperty
  a_window_set: assert property (p_window_set) else $error("Window flag not set.");

  property p_watch_off;
    !regular_watch_enable && !event_flags[`ADFW_FLG_WINDOW] &&
      !(wr_access && (sel == adfw_pkg::ADFW_SEL_WATCH)) |=> !event_flags[`ADFW_FLG_WINDOW];
  endproperty
  a_watch_off: assert property (p_watch_off) else $error("Window flag set while watch off.");

  property p_single;
    single_channel_watch && (conv_channel != watched_channel_select) |-> !watch_hit;
  endproperty
  a_single: assert property (p_single) else $error("Unselected channel was checked.");

  property p_abort;
    scan_abort |-> $past(watch_interrupt_enable) && $past(sequence_scan_enable) && $past(watch_hit);
  endproperty
  a_abort: assert property (p_abort) else $error("Scan abort without cause.");

  property p_scan_group;
    sequence_scan_enable && conv_done && !conv_last && !event_flags[`ADFW_FLG_GROUP]
      |=> !event_flags[`ADFW_FLG_GROUP];
  endproperty
  a_scan_group: assert property (p_scan_group) else $error("Group done before last channel.");

  property p_irq_win;
    event_flags[`ADFW_FLG_WINDOW] && watch_interrupt_enable && !wr_access && !rd_access
      ##1 !wr_access |-> irq;
  endproperty
  a_irq_win: assert property (p_irq_win) else $error("Window interrupt missing.");

  property p_irq_quiet;
    !(|event_mask) && !any_channel_interrupt_enable && !watch_interrupt_enable &&
      !group_done_interrupt_enable ##1 !(|event_mask) |-> !irq;
  endproperty
  a_irq_quiet: assert property (p_irq_quiet) else $error("Interrupt with nothing enabled.");

  // The interrupt register saw the enable of the cycle before the flag rose.
  property p_irq_any;
    $rose(event_flags[`ADFW_FLG_ANY]) && $past(any_channel_interrupt_enable) |-> irq;
  endproperty
  a_irq_any: assert property (p_irq_any) else $error("Any-done interrupt missing.");

  property p_group_set;
    conv_done && (!sequence_scan_enable || conv_last) |=> event_flags[`ADFW_FLG_GROUP];
  endproperty
  a_group_set: assert property (p_group_set) else $error("Group flag not set.");

  property p_window_low;
    conv_done && regular_watch_enable && !single_channel_watch &&
      (conv_result < window_low_limit) |=> event_flags[`ADFW_FLG_WINDOW];
  endproperty
  a_window_low: assert property (p_window_low) else $error("Window flag not set below low limit.");

  property p_window_chan;
    conv_done && regular_watch_enable && single_channel_watch && (conv_channel == watched_channel_select) &&
      (watched_channel_select <= `ADFW_CHAN_MAX) && (conv_result > window_high_limit)
      |=> event_flags[`ADFW_FLG_WINDOW];
  endproperty
  a_window_chan: assert property (p_window_chan) else $error("Selected channel not checked.");

  property p_irq_group;
    event_flags[`ADFW_FLG_GROUP] && group_done_interrupt_enable &&
      !(wr_access && (sel == adfw_pkg::ADFW_SEL_FLAGS)) |=> irq;
  endproperty
  a_irq_group: assert property (p_irq_group) else $error("Group-done interrupt missing.");

  property p_abort_set;
    watch_hit && sequence_scan_enable && watch_interrupt_enable |=> scan_abort;
  endproperty
  a_abort_set: assert property (p_abort_set) else $error("Scan not aborted on a window hit.");

  property p_no_abort;
    !watch_interrupt_enable |=> !scan_abort;
  endproperty
  a_no_abort: assert property (p_no_abort) else $error("Scan aborted with watch interrupt off.");

  property p_log_irq;
    (|(event_log & event_mask)) && !(rd_access && (sel == adfw_pkg::ADFW_SEL_LOG)) |=> irq;
  endproperty
  a_log_irq: assert property (p_log_irq) else $error("Logged event interrupt missing.");

  property p_any_clear;
    wr_access && (sel == adfw_pkg::ADFW_SEL_FLAGS) && !pwdata[`ADFW_FLG_ANY] && !conv_done
      |=> !event_flags[`ADFW_FLG_ANY];
  endproperty
  a_any_clear: assert property (p_any_clear) else $error("Any-done flag not cleared by a zero write.");

endmodule : adfw_top

// ---- adfw_top_tb_top.sv ----
// Self-checking testbench of the converter flag and window watch block.
`include "adfw_params.svh"

module adfw_top_tb_top;
  timeunit 1ns;
  timeprecision 1ps;

  logic                  sys_clk;
  logic                  nrst;
  logic                  psel;
  logic                  penable;
  logic                  pwrite;
  logic [7:0]            paddr;
  logic [31:0]           pwdata;
  logic [31:0]           prdata;
  logic                  pready;
  logic                  pslverr;
  logic                  conv_start;
  logic                  conv_done;
  adfw_pkg::adfw_chan_t  conv_channel;
  adfw_pkg::adfw_sample_t conv_result;
  logic                  conv_last;
  logic                  sequence_scan_enable;
  adfw_pkg::adfw_sample_t window_high_limit;
  adfw_pkg::adfw_sample_t window_low_limit;
  logic                  scan_abort;
  logic                  irq;
  int                    n_errors = 0;
  int                    n_tests = 0;
  int                    cycles = 0;
  logic                  ab;
  logic                  er;
  logic [31:0]           rv;
  // Window cases: control value, channel, result and whether the window flag must set.
  logic [7:0]            wc [8] = '{8'h00, 8'ha0, 8'h80, 8'he3, 8'he3, 8'he9, 8'hea, 8'ha0};
  logic [3:0]            ch [8] = '{4'h1, 4'h4, 4'h7, 4'h5, 4'h3, 4'h9, 4'ha, 4'h2};
  logic [11:0]           res [8] = '{12'h900, 12'h900, 12'h0ff, 12'h900, 12'h0ff, 12'h900, 12'h900, 12'h800};
  logic                  ex [8] = '{1'b0, 1'b1, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0};

  adfw_top u_dut
  (
    .sys_clk              (sys_clk),
    .nrst                 (nrst),
    .psel                 (psel),
    .penable              (penable),
    .pwrite               (pwrite),
    .paddr                (paddr),
    .pwdata               (pwdata),
    .prdata               (prdata),
    .pready               (pready),
    .pslverr              (pslverr),
    .conv_start           (conv_start),
    .conv_done            (conv_done),
    .conv_channel         (conv_channel),
    .conv_result          (conv_result),
    .conv_last            (conv_last),
    .sequence_scan_enable (sequence_scan_enable),
    .window_high_limit    (window_high_limit),
    .window_low_limit     (window_low_limit),
    .scan_abort           (scan_abort),
    .irq                  (irq)
  );

  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end

  always @(posedge sys_clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 5000)
    begin
      n_errors++;
      summarize();
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic summarize();
    $display("tests %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : summarize

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r,
                     output logic e);
    @(posedge sys_clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    // Only the bench timeout ends a slave that never answers.
    do
      @(posedge sys_clk);
    while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, d, r, e);
  endtask : wr

  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] r;
    logic        e;
    apb(1'b0, a, 32'h0, r, e);
    check(r, exp);
  endtask : rdchk

  task automatic irqchk(input logic exp);
    repeat (2) @(negedge sys_clk);
    check({31'h0, irq}, {31'h0, exp});
    @(posedge sys_clk);
  endtask : irqchk

  task automatic conv(input logic st, input logic dn, input logic [3:0] c, input logic [11:0] v,
                      input logic last, output logic abort);
    @(posedge sys_clk);
    conv_start   <= st;
    conv_done    <= dn;
    conv_channel <= c;
    conv_result  <= v;
    conv_last    <= last;
    @(posedge sys_clk);
    conv_start <= 1'b0;
    conv_done  <= 1'b0;
    @(negedge sys_clk);
    abort = scan_abort;
  endtask : conv

  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    nrst = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    conv_start = 1'b0;
    conv_done = 1'b0;
    conv_channel = 4'h0;
    conv_result = 12'h000;
    conv_last = 1'b0;
    sequence_scan_enable = 1'b1;
    window_high_limit = 12'h800;
    window_low_limit = 12'h100;
    repeat (5) @(posedge sys_clk);
    nrst <= 1'b1;
    rdchk(`ADFW_OFF_FLAGS, 32'h0);
    rdchk(`ADFW_OFF_WATCH, 32'h0);
    rdchk(`ADFW_OFF_CTRL3, 32'h0);
    irqchk(1'b0);
    $display("test reset done");
    conv(1'b1, 1'b0, 4'h0, 12'h000, 1'b0, ab);
    rdchk(`ADFW_OFF_FLAGS, 32'h4);
    irqchk(1'b0);
    wr(`ADFW_OFF_FLAGS, 32'hb);
    rdchk(`ADFW_OFF_FLAGS, 32'h0);
    $display("test began flag done");
    conv(1'b0, 1'b1, 4'h2, 12'h400, 1'b0, ab);
    rdchk(`ADFW_OFF_FLAGS, 32'h8);
    irqchk(1'b0);
    wr(`ADFW_OFF_CTRL3, 32'h10);
    irqchk(1'b1);
    wr(`ADFW_OFF_FLAGS, 32'h7);
    rdchk(`ADFW_OFF_FLAGS, 32'h0);
    irqchk(1'b0);
    conv(1'b0, 1'b1, 4'h2, 12'h400, 1'b0, ab);
    irqchk(1'b1);
    wr(`ADFW_OFF_FLAGS, 32'h7);
    wr(`ADFW_OFF_CTRL3, 32'h0);
    $display("test any channel done");
    conv(1'b0, 1'b1, 4'h9, 12'h400, 1'b1, ab);
    rdchk(`ADFW_OFF_FLAGS, 32'ha);
    irqchk(1'b0);
    wr(`ADFW_OFF_WATCH, 32'h10);
    irqchk(1'b1);
    wr(`ADFW_OFF_FLAGS, 32'hd);
    rdchk(`ADFW_OFF_FLAGS, 32'h8);
    irqchk(1'b0);
    sequence_scan_enable <= 1'b0;
    conv(1'b0, 1'b1, 4'h0, 12'h400, 1'b0, ab);
    rdchk(`ADFW_OFF_FLAGS, 32'ha);
    irqchk(1'b1);
    sequence_scan_enable <= 1'b1;
    $display("test group done");
    for (int i = 0; i < 8; i++)
    begin
      wr(`ADFW_OFF_WATCH, {24'h0, wc[i]});
      wr(`ADFW_OFF_FLAGS, 32'h0);
      conv(1'b0, 1'b1, ch[i], res[i], 1'b0, ab);
      check({31'h0, ab}, {31'h0, ex[i] & wc[i][5]});
      rdchk(`ADFW_OFF_FLAGS, {28'h0, 3'b100, ex[i]});
      rdchk(`ADFW_OFF_WATCH, {24'h0, wc[i]});
      irqchk(ex[i] & wc[i][5]);
    end
    $display("test window watch done");
    apb(1'b0, 8'h08, 32'h0, rv, er);
    check(rv, 32'h0);
    check({31'h0, er}, 32'h1);
    wr(`ADFW_OFF_WATCH, 32'h0);
    wr(`ADFW_OFF_FLAGS, 32'h0);
    apb(1'b0, `ADFW_OFF_LOG, 32'h0, rv, er);
    wr(`ADFW_OFF_MASK, 32'h2);
    sequence_scan_enable <= 1'b0;
    conv(1'b0, 1'b1, 4'h1, 12'h400, 1'b0, ab);
    irqchk(1'b1);
    rdchk(`ADFW_OFF_LOG, 32'ha);
    rdchk(`ADFW_OFF_LOG, 32'h0);
    irqchk(1'b0);
    $display("test unmapped and log done");
    summarize();
  end

endmodule : adfw_top_tb_top

// ---- adfw_window_cmp.sv ----
// Window comparator: flags a sample that lies outside the low and high limits.
`include "adfw_params.svh"

module adfw_window_cmp
(
  input  wire adfw_pkg::adfw_sample_t sample,
  input  wire adfw_pkg::adfw_sample_t high_limit,
  input  wire adfw_pkg::adfw_sample_t low_limit,
  output logic                        outside
);

  // Strictly above the high limit or strictly below the low limit.
  assign outside = (sample > high_limit) || (sample < low_limit);

endmodule : adfw_window_cmp
